/* hdl/flash_self_program_pkg.sv */
package flash_self_program_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [1:0] ptr_low_addr    = 2'h0;
  localparam logic [1:0] ptr_high_addr   = 2'h1;
  localparam logic [1:0] ctrl_addr       = 2'h2;
  localparam logic [7:0] ctrl_reset      = 8'h00;
  localparam logic [7:0] ptr_reset       = 8'h00;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int arm_bit      = 0;
  localparam int erase_bit    = 1;
  localparam int write_bit    = 2;
  localparam int select_bit   = 3;
  localparam int reenable_bit = 4;
  localparam int busy_bit     = 6;

  localparam logic [4:0] cmd_reenable = 5'h11;
  localparam logic [4:0] cmd_lockread = 5'h09;
  localparam logic [4:0] cmd_pgwrite  = 5'h05;
  localparam logic [4:0] cmd_pgerase  = 5'h03;
  localparam logic [4:0] cmd_buffill  = 5'h01;

  // ----------------------------------------------------------------
  // pointer fields and special addresses
  // ----------------------------------------------------------------
  localparam int word_bits  = 6;
  localparam int page_bits  = 8;
  localparam int flash_abits = 14;
  localparam logic [15:0] fuse_low_addr  = 16'h0000;
  localparam logic [15:0] lock_addr      = 16'h0001;
  localparam logic [15:0] fuse_ext_addr  = 16'h0002;
  localparam logic [15:0] fuse_high_addr = 16'h0003;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int load_window  = 3;
  localparam int store_window = 4;
  localparam real prog_time_min_ms = 3.7;
  localparam real prog_time_max_ms = 4.5;
  localparam int rc_rate_khz = 8000;
  // aim for the middle of the min/max band, counted in rc ticks
  localparam int prog_rc_ticks = int'((prog_time_min_ms + prog_time_max_ms) / 2.0 * rc_rate_khz);

  typedef enum logic [1:0] {op_idle, op_erase, op_write, op_lockwr} op_t;

endpackage

/* hdl/page_buffer_mem.sv */
`timescale 1ns/1ps
module page_buffer_mem (
  input  wire logic        clock_i,
  input  wire logic        wr_en_i,
  input  wire logic [5:0]  wr_addr_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic [5:0]  rd_addr_i,
  output logic      [15:0] rd_data_o
);
  logic [15:0] mem [0:63];

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

/* hdl/prog_timer.sv */
`timescale 1ns/1ps
// counts rc oscillator ticks; the tick is synchronised in the parent
module prog_timer #(
  parameter int ticks = flash_self_program_pkg::prog_rc_ticks
) (
  input  wire logic clock_i,
  input  wire logic start_i,
  input  wire logic rc_tick_i,
  output logic      done_o
);
  // no reset: a running operation survives a system reset, so only power-up values
  logic [16:0] count_r = 17'h00000;
  logic        run_r   = 1'b0;

  always_ff @(posedge clock_i) begin
    done_o <= 1'b0;
    if (start_i) begin
      run_r   <= 1'b1;
      count_r <= 17'(ticks);
    end else if (run_r && rc_tick_i) begin
      if (count_r == 17'h00001) begin
        run_r  <= 1'b0;
        done_o <= 1'b1;
      end
      count_r <= count_r - 17'h00001;
    end
  end
endmodule

/* hdl/flash_self_program_access.sv */
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module flash_self_program_access #(
  parameter int prog_ticks = flash_self_program_pkg::prog_rc_ticks
) (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic [1:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        store_i,
  input  wire logic [15:0] store_data_i,
  input  wire logic        load_i,
  output logic [7:0]       load_data_o,
  output logic             load_valid_o,
  input  wire logic        eeprom_write_active_i,
  input  wire logic        rc_clk_i,
  input  wire logic [7:0]  fuse_low_byte_i,
  input  wire logic [7:0]  fuse_high_byte_i,
  input  wire logic [7:0]  fuse_extended_byte_i,
  input  wire logic [7:0]  lock_byte_i,
  output logic [flash_self_program_pkg::flash_abits-1:0] flash_addr_o,
  input  wire logic [15:0] flash_rdata_i,
  output logic             flash_erase_o,
  output logic             flash_write_o,
  output logic [7:0]       lock_wr_data_o,
  output logic [15:0]      buf_rdata_o,
  output logic             cpu_halt_o,
  output logic             no_concurrent_only_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] ee_sync_r;
  logic [2:0] rc_sync_r;
  logic       ee_busy;
  logic       rc_tick;

  always_ff @(posedge clock_i) begin
    ee_sync_r <= {ee_sync_r[0], eeprom_write_active_i};
    rc_sync_r <= {rc_sync_r[1:0], rc_clk_i};
  end
  assign ee_busy = ee_sync_r[1];
  assign rc_tick = rc_sync_r[1] & ~rc_sync_r[2];

  // ----------------------------------------------------------------
  // address pointer
  // ----------------------------------------------------------------
  logic [7:0]  ptr_low_r;
  logic [7:0]  ptr_high_r;
  logic [15:0] pointer;
  logic [7:0]  page_idx;
  logic [5:0]  word_idx;

  assign pointer  = {ptr_high_r, ptr_low_r};
  assign word_idx = pointer[6:1];
  assign page_idx = pointer[14:7];

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      ptr_low_r  <= flash_self_program_pkg::ptr_reset;
      ptr_high_r <= flash_self_program_pkg::ptr_reset;
    end else if (reg_wr_i && reg_addr_i == flash_self_program_pkg::ptr_low_addr) begin
      ptr_low_r <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == flash_self_program_pkg::ptr_high_addr) begin
      ptr_high_r <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // control register and command windows
  // ----------------------------------------------------------------
  logic [4:0] cmd_r;
  logic [2:0] window_r;
  logic       op_busy;
  logic       ctrl_wr;
  logic       cmd_ok;
  logic       armed;
  logic       lockrd_armed;
  logic       lockrd_hit;
  logic       store_hit;
  logic       op_done;
  // power-up value only; a system reset must not abort a running operation
  flash_self_program_pkg::op_t op_r = flash_self_program_pkg::op_idle;

  assign ctrl_wr = reg_wr_i && reg_addr_i == flash_self_program_pkg::ctrl_addr;
  assign cmd_ok  = reg_wdata_i[4:0] == flash_self_program_pkg::cmd_reenable ||
                   reg_wdata_i[4:0] == flash_self_program_pkg::cmd_lockread ||
                   reg_wdata_i[4:0] == flash_self_program_pkg::cmd_pgwrite ||
                   reg_wdata_i[4:0] == flash_self_program_pkg::cmd_pgerase ||
                   reg_wdata_i[4:0] == flash_self_program_pkg::cmd_buffill;
  assign op_busy      = op_r != flash_self_program_pkg::op_idle;
  assign armed        = cmd_r[flash_self_program_pkg::arm_bit] && !op_busy;
  assign lockrd_armed = armed && cmd_r == flash_self_program_pkg::cmd_lockread;
  assign lockrd_hit   = lockrd_armed && load_i && !ee_busy &&
                        window_r <= 3'(flash_self_program_pkg::load_window);
  assign store_hit    = armed && store_i && !ee_busy;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      cmd_r    <= 5'h00;
      window_r <= 3'h0;
    end else if (ctrl_wr && !op_busy) begin
      if (cmd_ok && !ee_busy) begin
        cmd_r    <= reg_wdata_i[4:0];
        window_r <= 3'h1;
      end
    end else if (op_busy) begin
      window_r <= 3'h0; // arm stays high until the operation ends
      if (op_done) begin
        cmd_r <= 5'h00;
      end
    end else if (cmd_r != 5'h00) begin
      if (lockrd_hit || store_hit) begin
        cmd_r <= (store_hit && (cmd_r == flash_self_program_pkg::cmd_pgerase ||
                  cmd_r == flash_self_program_pkg::cmd_pgwrite)) ? cmd_r : 5'h00;
      end else if (lockrd_armed && window_r >= 3'(flash_self_program_pkg::load_window)) begin
        cmd_r <= 5'h00;
      end else if (window_r >= 3'(flash_self_program_pkg::store_window)) begin
        cmd_r <= 5'h00;
      end
      window_r <= window_r + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // long operations; op state survives reset so writes complete
  // ----------------------------------------------------------------
  logic start_op;
  assign start_op = store_hit && (cmd_r == flash_self_program_pkg::cmd_pgerase ||
                                  cmd_r == flash_self_program_pkg::cmd_pgwrite ||
                                  cmd_r == flash_self_program_pkg::cmd_lockread);

  always_ff @(posedge clock_i) begin
    if (op_done) begin
      op_r <= flash_self_program_pkg::op_idle;
    end else if (start_op) begin
      case (cmd_r)
        flash_self_program_pkg::cmd_pgerase: op_r <= flash_self_program_pkg::op_erase;
        flash_self_program_pkg::cmd_pgwrite: op_r <= flash_self_program_pkg::op_write;
        default:                             op_r <= flash_self_program_pkg::op_lockwr;
      endcase
    end
  end

  prog_timer #(
    .ticks(prog_ticks)
  ) u_timer (
    .clock_i   (clock_i),
    .start_i   (start_op),
    .rc_tick_i (rc_tick),
    .done_o    (op_done)
  );

  // ----------------------------------------------------------------
  // temporary page buffer
  // ----------------------------------------------------------------
  logic buf_wr;
  assign buf_wr = store_hit && cmd_r == flash_self_program_pkg::cmd_buffill;

  page_buffer_mem u_buf (
    .clock_i   (clock_i),
    .wr_en_i   (buf_wr),
    .wr_addr_i (word_idx),
    .wr_data_i (store_data_i),
    .rd_addr_i (word_idx),
    .rd_data_o (buf_rdata_o)
  );

  // ----------------------------------------------------------------
  // flash side and cpu halt
  // ----------------------------------------------------------------
  // page is latched at the start: a reset in mid-operation clears the pointer,
  // and the flash must keep seeing the page that was started
  logic [7:0] op_page_r;

  always_ff @(posedge clock_i) begin
    if (start_op) begin
      op_page_r <= page_idx;
    end
  end

  always_ff @(posedge clock_i) begin
    flash_erase_o        <= op_r == flash_self_program_pkg::op_erase;
    flash_write_o        <= op_r == flash_self_program_pkg::op_write;
    cpu_halt_o           <= op_r == flash_self_program_pkg::op_erase ||
                            op_r == flash_self_program_pkg::op_write;
    no_concurrent_only_o <= op_r == flash_self_program_pkg::op_erase ||
                            op_r == flash_self_program_pkg::op_write;
    if (start_op) begin
      lock_wr_data_o <= store_data_i[7:0];
    end
    if (op_busy) begin
      flash_addr_o <= {op_page_r, 6'h00};
    end else begin
      flash_addr_o <= pointer[14:1];
    end
  end

  // ----------------------------------------------------------------
  // program loads
  // ----------------------------------------------------------------
  logic       load_d_r;
  logic       byte_select_bit_r;
  logic       special_r;
  logic [7:0] special_byte_r;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      load_d_r <= 1'b0;
      load_valid_o <= 1'b0;
      special_r <= 1'b0;
      special_byte_r <= 8'hFF;
      byte_select_bit_r <= 1'b0;
      load_data_o <= 8'h00;
    end else begin
      load_d_r <= load_i && !lockrd_hit;
      special_r <= lockrd_hit;
      byte_select_bit_r <= pointer[0];
      if (lockrd_hit) begin // fuse bytes carry programmed-as-zero already
        if (pointer == flash_self_program_pkg::lock_addr) begin
          special_byte_r <= lock_byte_i;
        end else if (pointer == flash_self_program_pkg::fuse_low_addr) begin
          special_byte_r <= fuse_low_byte_i;
        end else if (pointer == flash_self_program_pkg::fuse_high_addr) begin
          special_byte_r <= fuse_high_byte_i;
        end else if (pointer == flash_self_program_pkg::fuse_ext_addr) begin
          special_byte_r <= fuse_extended_byte_i;
        end else begin
          special_byte_r <= 8'hFF;
        end
      end
      load_valid_o <= load_d_r || special_r;
      if (special_r) begin
        load_data_o <= special_byte_r;
      end else if (load_d_r) begin
        load_data_o <= byte_select_bit_r ? flash_rdata_i[15:8] : flash_rdata_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == flash_self_program_pkg::ptr_low_addr) begin
        reg_rdata_o <= ptr_low_r;
      end else if (reg_addr_i == flash_self_program_pkg::ptr_high_addr) begin
        reg_rdata_o <= ptr_high_r;
      end else if (reg_addr_i == flash_self_program_pkg::ctrl_addr) begin
        reg_rdata_o <= {3'h0, cmd_r[4:1], cmd_r[0] | op_busy};
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

endmodule

/* sim/flash_access_chk.sv */
`timescale 1ns/1ps
module flash_access_chk #(
  parameter int prog_ticks = 20
) (
  input wire logic       clock_i,
  input wire logic       rst_b_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       load_i,
  input wire logic       load_valid_o,
  input wire logic       rc_clk_i,
  input wire logic       flash_erase_o,
  input wire logic       flash_write_o,
  input wire logic       cpu_halt_o,
  input wire logic       no_concurrent_only_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------
  // rc edges seen while an operation runs
  // ----------------------------------------
  logic rc_q;
  int   rc_seen;
  wire  op = flash_erase_o | flash_write_o;
  always_ff @(posedge clock_i) begin
    rc_q <= rc_clk_i;
    if (!op) rc_seen <= 0;
    else if (rc_clk_i && !rc_q) rc_seen <= rc_seen + 1;
  end
  prog_time_a: assert property ($fell(op) |-> rc_seen >= prog_ticks - 3 && rc_seen <= prog_ticks + 3)
    else $error("operation length off");
  load_answer_a: assert property (load_i |-> ##2 load_valid_o)
    else $error("load not answered");
  valid_cause_a: assert property (load_valid_o |-> $past(load_i, 2))
    else $error("answer without load");
  halt_op_a: assert property (op |-> cpu_halt_o)
    else $error("core not halted");
  no_concurrent_read_section_only_a: assert property (op |-> no_concurrent_only_o)
    else $error("section gate open during op");
  op_exclusive_a: assert property (!(flash_erase_o && flash_write_o))
    else $error("erase and write together");
  unmapped_zero_a: assert property (reg_rd_i && reg_addr_i == 2'h3 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  busy_zero_a: assert property (reg_rd_i && reg_addr_i == flash_self_program_pkg::ctrl_addr
    |=> !reg_rdata_o[flash_self_program_pkg::busy_bit])
    else $error("busy bit set");
  ptr_readback_a: assert property ((reg_wr_i && reg_addr_i == flash_self_program_pkg::ptr_low_addr) ##1
    (reg_rd_i && reg_addr_i == flash_self_program_pkg::ptr_low_addr) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("pointer readback wrong");
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  cover property ($rose(flash_erase_o));
  cover property ($rose(flash_write_o));
  cover property (load_valid_o);
endmodule

bind flash_self_program_access flash_access_chk #(.prog_ticks(prog_ticks)) chk_u (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .load_i(load_i),
  .load_valid_o(load_valid_o), .rc_clk_i(rc_clk_i), .flash_erase_o(flash_erase_o),
  .flash_write_o(flash_write_o), .cpu_halt_o(cpu_halt_o), .no_concurrent_only_o(no_concurrent_only_o));

/* sim/cpu_core_model.sv */
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic   clock_i,
  input  wire logic   cpu_halt_i,
  output logic        store_o,
  output logic [15:0] store_data_o,
  output logic        load_o
);
  initial begin
    store_o = 1'b0;
    store_data_o = 16'h0000;
    load_o = 1'b0;
  end
  // gap counts edges after the control write; a halted core issues nothing for up to 4000 edges
  task automatic issue(input bit is_store, input int gap, input logic [15:0] d);
    int n;
    n = 0;
    repeat (gap - 1) @(posedge clock_i);
    while (cpu_halt_i === 1'b1 && n < 4000) begin
      @(posedge clock_i);
      n++;
    end
    if (is_store) begin
      store_o <= 1'b1;
      store_data_o <= d;
    end else load_o <= 1'b1;
    @(posedge clock_i);
    store_o <= 1'b0;
    load_o <= 1'b0;
    // released data lines do not keep the last value
    store_data_o <= ~d;
  endtask
endmodule

/* sim/test_flash_self_program_access.sv */
`timescale 1ns/1ps
module test_flash_self_program_access;
  localparam int ticks = 20;
  localparam logic [1:0] ctl = flash_self_program_pkg::ctrl_addr;
  localparam logic [7:0] spec_exp [4] = '{8'h5A, 8'hC3, 8'h96, 8'h3C};
  localparam logic [7:0] codes [8] = '{8'h11, 8'h09, 8'h05, 8'h03, 8'h01, 8'h07, 8'h0F, 8'h02};
  logic        clock, rst_b, rc_clk, reg_wr, reg_rd, ee_busy, store, load, ld_valid;
  logic        erase, write, halt, no_concurrent_read_section;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, ld_data, got;
  logic [15:0] st_data, buf_rd, flash_rd;
  logic [13:0] faddr;
  int          err_total, samples_checked, n;
  // flash content is a fixed function of the word address
  assign flash_rd = {faddr[7:0], ~faddr[13:6]};
  function automatic logic [7:0] exp_byte(input logic [15:0] p);
    logic [15:0] w;
    w = {~p[14:7], p[8:1]};
    return p[0] ? w[7:0] : w[15:8];
  endfunction
  flash_self_program_access #(.prog_ticks(ticks)) uut (
    .clock_i(clock), .rst_b_i(rst_b), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .store_i(store), .store_data_i(st_data), .load_i(load),
    .load_data_o(ld_data), .load_valid_o(ld_valid), .eeprom_write_active_i(ee_busy), .rc_clk_i(rc_clk),
    .fuse_low_byte_i(spec_exp[0]), .fuse_high_byte_i(spec_exp[3]), .fuse_extended_byte_i(spec_exp[2]),
    .lock_byte_i(spec_exp[1]), .flash_addr_o(faddr), .flash_rdata_i(flash_rd), .flash_erase_o(erase),
    .flash_write_o(write), .lock_wr_data_o(), .buf_rdata_o(buf_rd), .cpu_halt_o(halt),
    .no_concurrent_only_o(no_concurrent_read_section));
  cpu_core_model core (.clock_i(clock), .cpu_halt_i(halt), .store_o(store), .store_data_o(st_data), .load_o(load));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // rc period is ten system cycles, phase unrelated
  initial begin
    rc_clk = 1'b0;
    #1.3;
    forever #20 rc_clk = ~rc_clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
  // strobe stays high across both bytes, then one idle cycle so the next call never re-raises it
  task automatic set_ptr(input logic [15:0] p);
    reg_addr <= flash_self_program_pkg::ptr_low_addr;
    reg_wdata <= p[7:0];
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_addr <= flash_self_program_pkg::ptr_high_addr;
    reg_wdata <= p[15:8];
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic take(input string what, input int gap, input logic [7:0] exp);
    int k;
    k = 0;
    core.issue(1'b0, gap, 16'h0000);
    while (ld_valid !== 1'b1 && k < 4) begin
      @(posedge clock);
      k++;
    end
    chk("load valid", 16'h0001, {15'h0000, ld_valid});
    chk(what, {8'h00, exp}, {8'h00, ld_data});
  endtask
  task automatic run_op(input logic [7:0] cmd, input logic [15:0] p, input bit hit_reset);
    wr(ctl, cmd);
    core.issue(1'b1, 4, 16'h0000);
    repeat (3) @(posedge clock);
    chk("op running", 16'h0001, {15'h0000, cmd[1] ? erase : write});
    chk("page field", {8'h00, p[14:7]}, {8'h00, faddr[13:6]});
    rd(ctl, got);
    chk("arm during op", 16'h0001, {15'h0000, got[0]});
    if (hit_reset) begin
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      chk("write across reset", 16'h0001, {15'h0000, write});
    end
    n = 0;
    while ((erase | write) === 1'b1 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    chk("op length in range", 16'h0001, {15'h0000, n > ticks * 10 - 40 && n < ticks * 10 + 20});
    rd(ctl, got);
    chk("ctrl after op", 16'h0000, {8'h00, got});
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    err_total++;
    end_sim();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, ee_busy, reg_addr, reg_wdata} = '0;
    err_total = 0;
    samples_checked = 0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    rd(ctl, got);
    chk("ctrl reset", 16'h0000, {8'h00, got});
    rd(2'h3, got);
    chk("unmapped", 16'h0000, {8'h00, got});
    wr(flash_self_program_pkg::ptr_low_addr, 8'hA7);
    rd(flash_self_program_pkg::ptr_low_addr, got);
    chk("pointer low", 16'h00A7, {8'h00, got});
    foreach (codes[i]) begin
      wr(ctl, codes[i]);
      rd(ctl, got);
      chk("ctrl taken", {8'h00, i < 5 ? codes[i] : 8'h00}, {8'h00, got});
      repeat (6) @(posedge clock);
      rd(ctl, got);
      chk("ctrl lapsed", 16'h0000, {8'h00, got});
    end
    set_ptr(16'h1BA6);
    take("flash low byte", 1, exp_byte(16'h1BA6));
    set_ptr(16'h2C51);
    take("flash high byte", 1, exp_byte(16'h2C51));
    for (int i = 0; i < 4; i++) begin
      set_ptr(16'(i));
      wr(ctl, 8'h09);
      take("special byte", i == 1 ? 3 : 1, spec_exp[i]);
      rd(ctl, got);
      chk("ctrl after special", 16'h0000, {8'h00, got});
    end
    set_ptr(16'h0000);
    wr(ctl, 8'h09);
    take("late load", 4, exp_byte(16'h0000));
    ee_busy <= 1'b1;
    repeat (3) @(posedge clock);
    set_ptr(16'h0003);
    wr(ctl, 8'h09);
    take("load while eeprom busy", 1, exp_byte(16'h0003));
    wr(ctl, 8'h03);
    core.issue(1'b1, 1, 16'h0000);
    repeat (3) @(posedge clock);
    chk("erase while eeprom busy", 16'h0000, {15'h0000, erase});
    ee_busy <= 1'b0;
    repeat (4) @(posedge clock);
    set_ptr(16'h0086);
    wr(ctl, 8'h01);
    core.issue(1'b1, 4, 16'hBEEF);
    repeat (3) @(posedge clock);
    chk("buffer word", 16'hBEEF, buf_rd);
    wr(ctl, 8'h03);
    core.issue(1'b1, 5, 16'h0000);
    repeat (3) @(posedge clock);
    chk("late store", 16'h0000, {15'h0000, erase});
    set_ptr(16'h2C80);
    run_op(8'h03, 16'h2C80, 1'b0);
    run_op(8'h05, 16'h2C80, 1'b1);
    end_sim();
  end
endmodule
